// ===== emp_defs.vh
// Constants for the Ethernet PHY-facing port
`ifndef EMP_DEFS_VH
`define EMP_DEFS_VH
// System clock cycles per management clock half period
`define EMP_MDC_HALF      8'h04
// Management frame layout, bits sent most significant first
`define EMP_MDIO_BITS     7'h40
`define EMP_MDIO_LAST     7'h3f
`define EMP_MDIO_TA_IDX   7'h2e
`define EMP_MDIO_DATA_IDX 7'h30
`define EMP_MDIO_PREAMBLE 32'hffffffff
`define EMP_MDIO_START    2'h1
`define EMP_MDIO_OP_WR    2'h1
`define EMP_MDIO_OP_RD    2'h2
`define EMP_MDIO_TA_WR    2'h2
// Reset values
`define EMP_NIBBLE_RST    4'h0
`define EMP_PAIR_RST      2'h0
`define EMP_WORD_RST      16'h0000
// Width of the synchronised input group
`define EMP_SYNC_W        10
`endif

// ===== emp_phy.sv
// Behavioural PHY model on the far side of the port
`timescale 1ns/1ps
module emp_phy (
	// Device pins
	input wire         i_rmii_mode,
	input wire [3:0]   o_mii_transmit_nibble_out,
	input wire         o_mii_transmit_enable_out,
	input wire [1:0]   o_rmii_transmit_pair_out,
	input wire         o_rmii_transmit_enable_out,
	input wire         o_phy_mgmt_clock_out,
	input wire         o_phy_mgmt_data_io,
	input wire         o_phy_mgmt_data_io_oe,
	// Model outputs
	output logic       lclk,
	output logic [3:0] i_mii_receive_nibble_in,
	output wire  [1:0] i_rmii_receive_pair_in,
	output logic       i_mii_receive_valid_in,
	output wire        i_phy_mgmt_data_io
);
	logic [63:0] mframe;
	logic [15:0] rdval;
	logic        mdi;
	int          r;
	logic [4:0]  rxq[$];
	logic [3:0]  got[$];
	assign i_phy_mgmt_data_io = o_phy_mgmt_data_io_oe ? o_phy_mgmt_data_io : mdi;
	assign i_rmii_receive_pair_in = i_mii_receive_nibble_in[1:0];
	initial {lclk, mdi, i_mii_receive_valid_in, i_mii_receive_nibble_in} = 7'h0;
	always @(posedge o_phy_mgmt_data_io_oe) r = 0;
	always @(posedge o_phy_mgmt_clock_out)
	begin
		if (o_phy_mgmt_data_io_oe) mframe = {mframe[62:0], o_phy_mgmt_data_io};
		// Toggling outside the answer so a stale level never passes
		mdi = (r > 46 && r < 63) ? rdval[62 - r] : ~mdi;
		r++;
	end
	task run(input int n);
		#13;
		repeat (n)
		begin
			{i_mii_receive_valid_in, i_mii_receive_nibble_in} =
				rxq.size() ? rxq.pop_front() : {1'b0, ~i_mii_receive_nibble_in};
			#200 lclk = 1;
			if (i_rmii_mode ? o_rmii_transmit_enable_out : o_mii_transmit_enable_out)
				got.push_back(i_rmii_mode ? {2'h0, o_rmii_transmit_pair_out} : o_mii_transmit_nibble_out);
			#200 lclk = 0;
		end
	endtask
endmodule

// ===== emp_port.v
// Ethernet port PHY-facing logic: management line, MII and RMII data paths
//
// Summary of operation
// - Management data sampled on management clock rising edge
// - Management data line is bidirectional
// - MII transmit data is a 4-bit nibble
// - RMII transmit uses only two low lines
// - MII transmit enable signals activity, clock-synchronous
// - RMII enable spans preamble through last bits
// - Receive nibble meaningful only while valid high
// - RMII receive takes two low lines only
`timescale 1ns/1ps
`include "emp_defs.vh"
module emp_port #(
	parameter [7:0] MDC_HALF = `EMP_MDC_HALF
) (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rstn,
	// Mode: high selects RMII
	input  wire        i_rmii_mode,
	// Management command side
	input  wire        i_mgmt_start,
	input  wire        i_mgmt_write,
	input  wire [4:0]  i_mgmt_phy,
	input  wire [4:0]  i_mgmt_reg,
	input  wire [15:0] i_mgmt_wdata,
	output reg         o_mgmt_busy,
	output reg         o_mgmt_done,
	output reg  [15:0] o_mgmt_rdata,
	// Management pins
	output reg         o_phy_mgmt_clock_out,
	input  wire        i_phy_mgmt_data_io,
	output reg         o_phy_mgmt_data_io,
	output reg         o_phy_mgmt_data_io_oe,
	// Transmit user side
	input  wire        i_tx_valid,
	input  wire [3:0]  i_tx_data,
	output reg         o_tx_ready,
	// Transmit pins
	input  wire        i_mii_transmit_clock_in,
	output reg  [3:0]  o_mii_transmit_nibble_out,
	output reg         o_mii_transmit_enable_out,
	output reg  [1:0]  o_rmii_transmit_pair_out,
	output reg         o_rmii_transmit_enable_out,
	// Receive pins
	input  wire        i_mii_receive_clock_in,
	input  wire        i_rmii_reference_clock_in,
	input  wire [3:0]  i_mii_receive_nibble_in,
	input  wire [1:0]  i_rmii_receive_pair_in,
	input  wire        i_mii_receive_valid_in,
	input  wire        i_phy_collision_in,
	input  wire        i_phy_carrier_sense_in,
	// Receive user side
	output reg         o_rx_valid,
	output reg  [3:0]  o_rx_data,
	output reg         o_collision,
	output reg         o_carrier
);
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_RUN  = 2'b10;

	reg                  mode_q;
	wire [`EMP_SYNC_W-1:0] raw_in;
	wire [`EMP_SYNC_W-1:0] lvl;
	wire                 mdio_f;
	wire                 col_f;
	wire                 crs_f;
	wire                 txclk_f;
	wire                 rxclk_f;
	wire                 dv_f;
	wire [3:0]           rxd_f;
	reg                  txclk_prev_q;
	reg                  rxclk_prev_q;
	wire                 tx_rise;
	wire                 tx_fall;
	wire                 tx_launch;
	wire                 rx_rise;

	reg  [1:0]           state_q;
	reg  [7:0]           div_q;
	reg  [6:0]           bit_q;
	reg  [63:0]          shift_q;
	reg                  wr_q;
	wire                 div_wrap;
	wire [63:0]          frame;

	// Reference clock stands in for both transmit and receive clocks in RMII
	assign raw_in = {
		i_phy_mgmt_data_io,
		i_phy_collision_in,
		i_phy_carrier_sense_in,
		i_rmii_mode ? i_rmii_reference_clock_in : i_mii_transmit_clock_in,
		i_rmii_mode ? i_rmii_reference_clock_in : i_mii_receive_clock_in,
		i_mii_receive_valid_in,
		i_rmii_mode ? {2'b00, i_rmii_receive_pair_in} : i_mii_receive_nibble_in
	};

	// Clocks and data share one depth so they stay aligned
	emp_sync #(
		.WIDTH (`EMP_SYNC_W)
	) u_sync (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_async (raw_in),
		.o_level (lvl)
	);

	assign mdio_f  = lvl[9];
	assign col_f   = lvl[8];
	assign crs_f   = lvl[7];
	assign txclk_f = lvl[6];
	assign rxclk_f = lvl[5];
	assign dv_f    = lvl[4];
	assign rxd_f   = lvl[3:0];

	assign tx_rise = txclk_f & ~txclk_prev_q;
	assign tx_fall = ~txclk_f & txclk_prev_q;
	assign rx_rise = rxclk_f & ~rxclk_prev_q;
	// MII launches on fall, PHY samples on rise
	assign tx_launch = mode_q ? tx_rise : tx_fall;

	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			mode_q       <= 1'b0;
			txclk_prev_q <= 1'b0;
			rxclk_prev_q <= 1'b0;
		end
		else
		begin
			mode_q       <= i_rmii_mode;
			txclk_prev_q <= txclk_f;
			rxclk_prev_q <= rxclk_f;
		end
	end

	// Transmit path
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_tx_ready                 <= 1'b0;
			o_mii_transmit_nibble_out  <= `EMP_NIBBLE_RST;
			o_mii_transmit_enable_out  <= 1'b0;
			o_rmii_transmit_pair_out   <= `EMP_PAIR_RST;
			o_rmii_transmit_enable_out <= 1'b0;
		end
		else
		begin
			o_tx_ready <= tx_launch & i_tx_valid;
			if (tx_launch)
			begin
				if (mode_q)
				begin
					// pair on low lines, upper unused
					o_mii_transmit_nibble_out  <= `EMP_NIBBLE_RST;
					o_mii_transmit_enable_out  <= 1'b0;
					o_rmii_transmit_pair_out   <= i_tx_valid ? i_tx_data[1:0] : `EMP_PAIR_RST;
					// enable held while bits are presented
					o_rmii_transmit_enable_out <= i_tx_valid;
				end
				else
				begin
					o_mii_transmit_nibble_out  <= i_tx_valid ? i_tx_data : `EMP_NIBBLE_RST;
					o_mii_transmit_enable_out  <= i_tx_valid;
					o_rmii_transmit_pair_out   <= `EMP_PAIR_RST;
					o_rmii_transmit_enable_out <= 1'b0;
				end
			end
		end
	end

	// Receive path and line status
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_rx_valid  <= 1'b0;
			o_rx_data   <= `EMP_NIBBLE_RST;
			o_collision <= 1'b0;
			o_carrier   <= 1'b0;
		end
		else
		begin
			o_rx_valid <= rx_rise & dv_f;
			if (rx_rise & dv_f)
				o_rx_data <= rxd_f;
			o_collision <= ~mode_q & col_f;
			// carrier from PHY in MII; from receive valid in RMII
			o_carrier <= mode_q ? dv_f : crs_f;
		end
	end

	// Management frame: preamble, start, op, addresses, turnaround, data
	assign frame = {`EMP_MDIO_PREAMBLE, `EMP_MDIO_START,
		i_mgmt_write ? `EMP_MDIO_OP_WR : `EMP_MDIO_OP_RD,
		i_mgmt_phy, i_mgmt_reg,
		i_mgmt_write ? `EMP_MDIO_TA_WR : 2'b00,
		i_mgmt_write ? i_mgmt_wdata : `EMP_WORD_RST};
	assign div_wrap = (div_q == MDC_HALF - 8'h01);

	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_q               <= ST_IDLE;
			div_q                 <= 8'h00;
			bit_q                 <= 7'h00;
			shift_q               <= 64'h0;
			wr_q                  <= 1'b0;
			o_mgmt_busy           <= 1'b0;
			o_mgmt_done           <= 1'b0;
			o_mgmt_rdata          <= `EMP_WORD_RST;
			o_phy_mgmt_clock_out  <= 1'b0;
			o_phy_mgmt_data_io    <= 1'b0;
			o_phy_mgmt_data_io_oe <= 1'b0;
		end
		else
		begin
			o_mgmt_done <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					div_q <= 8'h00;
					if (i_mgmt_start)
					begin
						state_q               <= ST_RUN;
						shift_q               <= {frame[62:0], 1'b0};
						wr_q                  <= i_mgmt_write;
						bit_q                 <= 7'h00;
						o_mgmt_busy           <= 1'b1;
						o_phy_mgmt_data_io    <= frame[63];
						// drive the line for the request
						o_phy_mgmt_data_io_oe <= 1'b1;
					end
				end
				ST_RUN:
				begin
					div_q <= div_wrap ? 8'h00 : div_q + 8'h01;
					if (div_wrap & ~o_phy_mgmt_clock_out)
					begin
						o_phy_mgmt_clock_out <= 1'b1;
						// read bits taken at clock rise
						if (~wr_q && bit_q >= `EMP_MDIO_DATA_IDX)
							o_mgmt_rdata <= {o_mgmt_rdata[14:0], mdio_f};
					end
					else if (div_wrap)
					begin
						// Data moves on the fall, so it is settled at the rise
						o_phy_mgmt_clock_out <= 1'b0;
						if (bit_q == `EMP_MDIO_LAST)
						begin
							state_q               <= ST_IDLE;
							o_mgmt_busy           <= 1'b0;
							o_mgmt_done           <= 1'b1;
							o_phy_mgmt_data_io    <= 1'b0;
							o_phy_mgmt_data_io_oe <= 1'b0;
						end
						else
						begin
							bit_q              <= bit_q + 7'h01;
							shift_q            <= {shift_q[62:0], 1'b0};
							o_phy_mgmt_data_io <= shift_q[63];
							// release the line from turnaround on reads
							o_phy_mgmt_data_io_oe <= wr_q |
								(bit_q + 7'h01 < `EMP_MDIO_TA_IDX);
						end
					end
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// ===== emp_port_monitor.sv
// Port checker for the Ethernet PHY-facing block
`timescale 1ns/1ps
module emp_port_mon (
	// Clock and reset
	input wire       i_clk,
	input wire       i_rstn,
	// Watched ports
	input wire       i_rmii_mode,
	input wire       o_mgmt_busy,
	input wire       o_phy_mgmt_clock_out,
	input wire       o_phy_mgmt_data_io,
	input wire       o_phy_mgmt_data_io_oe,
	input wire       o_tx_ready,
	input wire [3:0] o_mii_transmit_nibble_out,
	input wire       o_mii_transmit_enable_out,
	input wire       o_rmii_transmit_enable_out,
	input wire       o_rx_valid,
	input wire [3:0] o_rx_data
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	property p_mdc_idle; !o_mgmt_busy |-> !o_phy_mgmt_clock_out; endproperty
	a_mdc_idle: assert property (p_mdc_idle) else $error("mdc idle");
	property p_md_hold;
		o_phy_mgmt_clock_out && $past(o_phy_mgmt_clock_out) |-> $stable(o_phy_mgmt_data_io);
	endproperty
	a_md_hold: assert property (p_md_hold) else $error("mdio moved");
	property p_oe_idle; !o_mgmt_busy |-> !o_phy_mgmt_data_io_oe; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
	property p_rmii_nib;
		i_rmii_mode [*3] |-> o_mii_transmit_nibble_out == 4'h0 && !o_mii_transmit_enable_out;
	endproperty
	a_rmii_nib: assert property (p_rmii_nib) else $error("nibble in rmii");
	property p_en_rise; $rose(o_mii_transmit_enable_out) |-> o_tx_ready; endproperty
	a_en_rise: assert property (p_en_rise) else $error("enable off launch");
	property p_ren_rise; $rose(o_rmii_transmit_enable_out) |-> o_tx_ready; endproperty
	a_ren_rise: assert property (p_ren_rise) else $error("renable off launch");
	property p_nib_launch;
		$changed(o_mii_transmit_nibble_out) |-> o_tx_ready || !o_mii_transmit_enable_out;
	endproperty
	a_nib_launch: assert property (p_nib_launch) else $error("nibble off launch");
	property p_rx_pair; i_rmii_mode [*3] ##0 o_rx_valid |-> o_rx_data[3:2] == 2'h0; endproperty
	a_rx_pair: assert property (p_rx_pair) else $error("pair high bits");
endmodule
bind emp_port emp_port_mon u_mon (.*);

// ===== emp_port_tb.sv
// Self-checking bench for the Ethernet PHY-facing port
`timescale 1ns/1ps
module emp_port_tb;
	logic        i_clk, i_rstn, i_rmii_mode, i_mgmt_start, i_mgmt_write, i_tx_valid, lclk;
	logic [4:0]  i_mgmt_phy, i_mgmt_reg;
	logic [15:0] i_mgmt_wdata, o_mgmt_rdata;
	logic [3:0]  i_tx_data, o_mii_transmit_nibble_out, o_rx_data, i_mii_receive_nibble_in;
	logic [1:0]  o_rmii_transmit_pair_out, i_rmii_receive_pair_in;
	logic        o_mgmt_busy, o_mgmt_done, o_phy_mgmt_clock_out, i_phy_mgmt_data_io;
	logic        o_phy_mgmt_data_io, o_phy_mgmt_data_io_oe, o_tx_ready, o_mii_transmit_enable_out;
	logic        o_rmii_transmit_enable_out, i_mii_receive_valid_in, i_phy_collision_in;
	logic        i_phy_carrier_sense_in, o_rx_valid, o_collision, o_carrier;
	wire         i_mii_transmit_clock_in = lclk, i_mii_receive_clock_in = lclk;
	wire         i_rmii_reference_clock_in = lclk;
	int          err_total, total_checks, j;
	logic [3:0]  rxgot[$];
	emp_port dut (.*);
	emp_phy phy (.*);
	initial
	begin
		i_clk = 0;
		forever #25 i_clk = ~i_clk;
	end
	always @(negedge i_clk) if (o_rx_valid) rxgot.push_back(o_rx_data);
	task chk(input logic [63:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task end_of_test;
		if (err_total == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task mgmt(input logic w, input logic [15:0] d);
		int k;
		phy.rdval = d;
		{i_mgmt_start, i_mgmt_write, i_mgmt_phy, i_mgmt_reg, i_mgmt_wdata} = {2'h2 | w, 10'h2aa, d};
		@(negedge i_clk);
		i_mgmt_start = 0;
		repeat (90) @(negedge i_clk);
		// Second start mid-frame must be ignored
		{i_mgmt_start, i_mgmt_wdata} = {1'b1, ~d};
		@(negedge i_clk);
		i_mgmt_start = 0;
		for (k = 0; k < 600 && !o_mgmt_done; k++) @(negedge i_clk);
		chk(o_mgmt_done, 1);
		chk(o_mgmt_busy, 0);
		if (w)
			chk(phy.mframe, {32'hffffffff, 4'h5, 10'h2aa, 2'h2, d});
		else
			chk({phy.mframe[45:0], o_mgmt_rdata}, {32'hffffffff, 4'h6, 10'h2aa, d});
		@(negedge i_clk);
	endtask
	task link(input logic m);
		i_rmii_mode = m;
		repeat (3) @(negedge i_clk);
		rxgot.delete();
		phy.got.delete();
		// Valid set once per step; the loop end lowers it after the last unit
		i_tx_valid = 1'b1;
		for (j = 0; j < 6; j++) phy.rxq.push_back({j != 3, 4'(j * 5 + 2)});
		fork
			phy.run(10);
			for (int t = 0; t < 6; t++)
			begin
				i_tx_data = 4'(t * 7 + 3);
				do @(negedge i_clk); while (!o_tx_ready);
				i_tx_valid = t < 5;
			end
		join
		chk(phy.got.size(), 6);
		foreach (phy.got[t]) chk(phy.got[t], 4'(t * 7 + 3) & (m ? 4'h3 : 4'hf));
		chk(rxgot.size(), 5);
		for (j = 0; j < 6; j++)
			if (j != 3) chk(rxgot.pop_front(), 4'(j * 5 + 2) & (m ? 4'h3 : 4'hf));
		// Model ends off the clock grid; realign so the next task drives on a fall
		@(negedge i_clk);
	endtask
	task status(input logic m);
		{i_rmii_mode, i_phy_collision_in, i_phy_carrier_sense_in} = {m, 2'h3};
		repeat (8) @(negedge i_clk);
		chk({o_collision, o_carrier}, m ? 2'h0 : 2'h3);
		{i_phy_collision_in, i_phy_carrier_sense_in} = {1'b0, m};
		repeat (8) @(negedge i_clk);
		chk({o_collision, o_carrier}, 2'h0);
	endtask
	initial
	begin
		{i_rstn, i_rmii_mode, i_mgmt_start, i_mgmt_write, i_tx_valid} = 5'h0;
		{i_phy_collision_in, i_phy_carrier_sense_in, i_tx_data} = 6'h0;
		{i_mgmt_phy, i_mgmt_reg, i_mgmt_wdata} = 26'h0;
		err_total = 0;
		total_checks = 0;
		repeat (16) @(negedge i_clk);
		chk({o_mgmt_busy, o_tx_ready, o_rx_valid, o_phy_mgmt_clock_out}, 0);
		i_rstn = 1;
		repeat (2) @(negedge i_clk);
		mgmt(1, 16'h8001);
		mgmt(0, 16'h5a3c);
		link(0);
		link(1);
		status(0);
		status(1);
		end_of_test;
	end
	// Runs near 1250 cycles; limit well above
	initial
	begin
		#1000000;
		err_total++;
		end_of_test;
	end
endmodule

// ===== emp_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module emp_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_rstn,
	// Asynchronous inputs
	input  wire [WIDTH-1:0] i_async,
	// Filtered level
	output reg  [WIDTH-1:0] o_level
);
	reg [WIDTH-1:0] s1_q;
	reg [WIDTH-1:0] s2_q;
	reg [WIDTH-1:0] s3_q;
	wire [WIDTH-1:0] level_d;

	// A bit moves only when stages two and three agree
	assign level_d = (s2_q & s3_q) | (o_level & (s2_q ^ s3_q));

	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			s1_q    <= {WIDTH{1'b0}};
			s2_q    <= {WIDTH{1'b0}};
			s3_q    <= {WIDTH{1'b0}};
			o_level <= {WIDTH{1'b0}};
		end
		else
		begin
			s1_q    <= i_async;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			o_level <= level_d;
		end
	end
endmodule
